// *** common/msc_defs.svh ***
/*
 * constants for the machine safety control core.
 * assumes inclusion by bare name from any design or bench file.
 */
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

// ************************************************************
// stop category codes
// ************************************************************
`define MSC_CAT0     2'h0
`define MSC_CAT1     2'h1
`define MSC_CAT2     2'h2
`define MSC_CAT_BAD  2'h3

// ************************************************************
// timing
// ************************************************************
`define MSC_CLK_HZ    32'h05F5_E100
`define MSC_MS_PER_S  32'h0000_03E8
`define MSC_TH_WIN_MS 32'h0000_01F4

`endif

// *** common/msc_pkg.sv ***
/*
 * types shared by the machine safety control core and its bench.
 * assumes nothing of its surroundings.
 */
package msc_pkg;

    // ************************************************************
    // modes and states
    // ************************************************************
    typedef enum logic [2:0] {
        MSC_MODE_NORMAL,
        MSC_MODE_HOLD,
        MSC_MODE_TH1,
        MSC_MODE_TH2,
        MSC_MODE_TH3
    } msc_mode_e;

    typedef enum logic [1:0] {
        MSC_ST_IDLE,
        MSC_ST_RUN,
        MSC_ST_CSTOP,
        MSC_ST_HELD
    } msc_state_e;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        msc_mode_e   mode;
        logic [1:0]  stop_cat;
        logic        estop_cat1;
        logic        en_use;
    } msc_cfg_s;

    typedef struct packed {
        logic power;
        logic motion;
        logic ctrl_stop;
    } msc_act_s;

endpackage : msc_pkg

// *** dv/msc_ops_model.sv ***
/*
 * far-side model: machine drives that report a finished controlled stop.
 * assumes the core's act bus on clk_sys.
 */
`timescale 1ns/10ps
module msc_ops_model (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // core side
    input  wire msc_pkg::msc_act_s act_q,
    input  wire logic              slow,
    // machine side
    output logic                   stop_done_q
);
    // ************************************************************
    // braking time
    // ************************************************************
    logic [3:0] cnt_q;

    // a heavy load brakes longer, so slow stretches the report
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q       <= 4'h0;
            stop_done_q <= 1'b0;
        end
        else if (!act_q.ctrl_stop)
        begin
            cnt_q       <= 4'h0;
            stop_done_q <= 1'b0;
        end
        else
        begin
            cnt_q       <= cnt_q + 4'h1;
            stop_done_q <= stop_done_q | (cnt_q == (slow ? 4'hC : 4'h2));
        end
    end
endmodule : msc_ops_model

// *** dv/tb_top.sv ***
/*
 * bench for msc_top: call sequences with expected actuator states.
 * assumes msc_pkg compiled first and msc_ops_model on the stop report.
 */
`timescale 1ns/10ps
module tb_top;
    logic              clk_sys;
    logic              rstn;
    logic [1:0]        start_pb;
    logic [1:0]        stop_pb;
    logic [1:0]        estop_pb;
    logic [1:0]        esw_pb;
    logic [1:0]        reset_pb;
    logic              hand_a;
    logic              hand_b;
    logic              enable_in;
    logic              hold_in;
    logic              prot_stop;
    logic              safety_ok;
    logic              stop_done;
    logic              slow;
    msc_pkg::msc_cfg_s cfg;
    logic [1:0]        stop_en;
    logic [1:0]        start_req;
    msc_pkg::msc_act_s act_q;
    logic              supply_on_q;
    logic [1:0]        estop_lat_q;
    logic [1:0]        esw_lat_q;
    logic              cfg_err_q;
    logic [1:0]        stn;
    int                fail_count = 0;
    int                samples_checked = 0;

    // ************************************************************
    // instances
    // ************************************************************
    msc_top #(.N_STN(2), .TH_WIN_CYC(20)) i_msc_top (
        .clk_sys(clk_sys), .rstn(rstn), .start_pb(start_pb), .stop_pb(stop_pb),
        .estop_pb(estop_pb), .esw_pb(esw_pb), .reset_pb(reset_pb), .hand_a(hand_a),
        .hand_b(hand_b), .enable_in(enable_in), .hold_in(hold_in),
        .prot_stop(prot_stop), .safety_ok(safety_ok), .stop_done(stop_done),
        .cfg(cfg), .stop_en(stop_en), .start_req(start_req), .act_q(act_q),
        .supply_on_q(supply_on_q), .estop_lat_q(estop_lat_q),
        .esw_lat_q(esw_lat_q), .cfg_err_q(cfg_err_q));

    msc_ops_model i_msc_ops_model (
        .clk_sys(clk_sys), .rstn(rstn), .act_q(act_q), .slow(slow),
        .stop_done_q(stop_done));

    always #5 clk_sys = ~clk_sys;

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic ck_act(input logic [2:0] exp);
        check("act", {5'h00, act_q}, {5'h00, exp});
    endtask : ck_act

    task automatic go(input logic [1:0] who);
        start_pb = who;
        wt(6);
        start_pb = 2'h0;
        wt(6);
    endtask : go

    task automatic halt;
        stop_pb = 2'h3;
        wt(6);
        stop_pb = 2'h0;
        wt(25);
    endtask : halt

    task automatic rst_stn(input logic [1:0] who);
        reset_pb = who;
        wt(6);
        reset_pb = 2'h0;
        wt(5);
    endtask : rst_stn

    task automatic hands(input logic a, input logic b);
        hand_a = a;
        hand_b = b;
        wt(6);
    endtask : hands

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    // ************************************************************
    // watchdog, about twenty-four times the expected run
    // ************************************************************
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        {start_pb, stop_pb, estop_pb, esw_pb, reset_pb} = 10'h000;
        {hand_a, hand_b, enable_in, hold_in, prot_stop, slow} = 6'h00;
        safety_ok = 1'b1;
        cfg = '0;
        stop_en = 2'h3;
        start_req = 2'h3;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        wt(6);
        check("supply", {7'h00, supply_on_q}, 8'h01);
        safety_ok = 1'b0;
        go(2'h3);
        ck_act(3'h0);
        safety_ok = 1'b1;
        go(2'h1);
        ck_act(3'h0);
        // stop with start held; category 3 is flagged and runs as 0
        for (int c = 0; c < 4; c++)
        begin
            cfg.stop_cat = 2'(c);
            slow = (c == 1);
            go(2'h3);
            ck_act(3'h6);
            stop_pb = 2'h2;
            start_pb = 2'h3;
            wt(4);
            ck_act((c == 1 || c == 2) ? 3'h5 : 3'h0);
            check("cfg_err", {7'h00, cfg_err_q}, {7'h00, c == 3});
            wt(25);
            stop_pb = 2'h0;
            start_pb = 2'h0;
            ck_act((c == 2) ? 3'h4 : 3'h0);
            // the release must reach the arm before the next press
            wt(6);
        end
        cfg.stop_cat = 2'h0;
        slow = 1'b0;
        stop_en = 2'h1;
        go(2'h3);
        stop_pb = 2'h2;
        wt(5);
        ck_act(3'h6);
        stop_pb = 2'h1;
        wt(5);
        ck_act(3'h0);
        stop_pb = 2'h0;
        stop_en = 2'h3;
        wt(3);
        go(2'h3);
        ck_act(3'h6);
        prot_stop = 1'b1;
        wt(5);
        prot_stop = 1'b0;
        wt(10);
        ck_act(3'h0);
        for (int k = 0; k < 2; k++)
        begin
            stn = 2'(1 << k);
            cfg.estop_cat1 = k[0];
            go(2'h3);
            estop_pb = stn;
            wt(4);
            ck_act(k ? 3'h5 : 3'h0);
            estop_pb = 2'h0;
            wt(25);
            ck_act(3'h0);
            check("estop_lat", {6'h00, estop_lat_q}, {6'h00, stn});
            go(2'h3);
            ck_act(3'h0);
            rst_stn(~stn);
            check("estop_lat", {6'h00, estop_lat_q}, {6'h00, stn});
            rst_stn(stn);
            check("estop_lat", {6'h00, estop_lat_q}, 8'h00);
            ck_act(3'h0);
            go(2'h3);
            ck_act(3'h6);
            halt();
        end
        go(2'h3);
        esw_pb = 2'h2;
        wt(4);
        check("supply", {7'h00, supply_on_q}, 8'h00);
        ck_act(3'h0);
        esw_pb = 2'h0;
        rst_stn(2'h1);
        check("supply", {7'h00, supply_on_q}, 8'h00);
        check("esw_lat", {6'h00, esw_lat_q}, 8'h02);
        rst_stn(2'h2);
        check("supply", {7'h00, supply_on_q}, 8'h01);
        ck_act(3'h0);
        cfg.mode = msc_pkg::MSC_MODE_HOLD;
        wt(5);
        hold_in = 1'b1;
        wt(6);
        ck_act(3'h6);
        hold_in = 1'b0;
        wt(5);
        ck_act(3'h0);
        cfg.mode = msc_pkg::MSC_MODE_TH1;
        wt(5);
        hands(1'b1, 1'b1);
        ck_act(3'h6);
        hands(1'b0, 1'b1);
        ck_act(3'h0);
        hands(1'b0, 1'b0);
        cfg.mode = msc_pkg::MSC_MODE_TH2;
        wt(5);
        hands(1'b1, 1'b1);
        ck_act(3'h6);
        hands(1'b1, 1'b0);
        ck_act(3'h0);
        hands(1'b1, 1'b1);
        ck_act(3'h0);
        hands(1'b0, 1'b0);
        hands(1'b1, 1'b1);
        ck_act(3'h6);
        hands(1'b0, 1'b0);
        hands(1'b1, 1'b1);
        cfg.mode = msc_pkg::MSC_MODE_TH3;
        wt(10);
        ck_act(3'h0);
        hands(1'b0, 1'b0);
        hand_a = 1'b1;
        wt(10);
        hands(1'b1, 1'b1);
        ck_act(3'h6);
        hands(1'b0, 1'b0);
        hand_a = 1'b1;
        wt(30);
        hands(1'b1, 1'b1);
        ck_act(3'h0);
        hands(1'b1, 1'b0);
        hands(1'b1, 1'b1);
        ck_act(3'h0);
        hands(1'b0, 1'b0);
        hands(1'b1, 1'b1);
        ck_act(3'h6);
        hands(1'b0, 1'b0);
        cfg.mode = msc_pkg::MSC_MODE_NORMAL;
        cfg.en_use = 1'b1;
        enable_in = 1'b1;
        wt(6);
        ck_act(3'h0);
        go(2'h3);
        ck_act(3'h6);
        enable_in = 1'b0;
        wt(5);
        ck_act(3'h0);
        go(2'h3);
        ck_act(3'h0);
        enable_in = 1'b1;
        wt(6);
        go(2'h3);
        ck_act(3'h6);
        halt();
        go(2'h3);
        ck_act(3'h0);
        give_verdict();
    end
endmodule : tb_top

// *** hdl/msc_top.sv ***
/*
 * start, stop, emergency stop, emergency switching off, hold-to-run,
 * two-hand and enabling control for one machine, several stations.
 * assumes: operator and feedback pins asynchronous; cfg and masks
 * come from logic on clk_sys and change only between operations.
 */
`timescale 1ns/10ps
`include "msc_defs.svh"

// How it works
// - start only while safety feedback reports all protective measures operational
// - multi-station start needs all starts released, then all pressed together
// - any active stop beats a simultaneous start
// - stop button of a station acts when its stop_en bit is set
// - protective stop clearing restarts two-hand type I with both hands held; other modes need a fresh start
// - normal stops run as category 0, 1 or 2 per configuration
// - emergency latch holds after actuator release until reset
// - only the raising station's reset clears its emergency latch
// - emergency reset re-arms; two-hand type I with both hands held restarts, other modes need a separate start
// - no restart while any emergency stop latch is set
// - supply stays off while any switching-off latch is set
// - emergency stop is category 0 or 1 only
// - emergency stop overrides every function in every mode
// - switching off removes supply, a category 0 stop of actuators
// - hold-to-run runs only while the hold input stays asserted
// - two-hand runs only while both hands stay asserted
// - two-hand types II and III need both hands released first
// - type III second hand must follow within 0,5 s
// - missed type III window waits for both hands released
// - enabling only permits; the start control initiates
// - enabling dropped stops and blocks initiation
// - enabling must be seen inactive before re-initiation
// - mode change alone starts only two-hand type I with both hands held; other modes need a separate start
module msc_top #(
    parameter int          N_STN      = 2,
    parameter int unsigned TH_WIN_CYC = `MSC_CLK_HZ / `MSC_MS_PER_S * `MSC_TH_WIN_MS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // station pins, asynchronous
    input  wire logic [N_STN-1:0]  start_pb,
    input  wire logic [N_STN-1:0]  stop_pb,
    input  wire logic [N_STN-1:0]  estop_pb,
    input  wire logic [N_STN-1:0]  esw_pb,
    input  wire logic [N_STN-1:0]  reset_pb,
    // machine pins, asynchronous
    input  wire logic              hand_a,
    input  wire logic              hand_b,
    input  wire logic              enable_in,
    input  wire logic              hold_in,
    input  wire logic              prot_stop,
    input  wire logic              safety_ok,
    input  wire logic              stop_done,
    // configuration
    input  wire msc_pkg::msc_cfg_s cfg,
    input  wire logic [N_STN-1:0]  stop_en,
    input  wire logic [N_STN-1:0]  start_req,
    // actuators and status
    output msc_pkg::msc_act_s      act_q,
    output logic                   supply_on_q,
    output logic [N_STN-1:0]       estop_lat_q,
    output logic [N_STN-1:0]       esw_lat_q,
    output logic                   cfg_err_q
);

    localparam int PW = 5 * N_STN + 7;
    localparam int TW = $clog2(TH_WIN_CYC + 1);

    generate
        if (N_STN < 1 || TH_WIN_CYC < 1)
        begin : g_bad_param
            $error("msc_top: N_STN and TH_WIN_CYC must be at least 1");
        end
    endgenerate

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic [PW-1:0] raw;
    logic [PW-1:0] sy1_q;
    logic [PW-1:0] sy2_q;

    assign raw = {start_pb, stop_pb, estop_pb, esw_pb, reset_pb, hand_a, hand_b,
                  enable_in, hold_in, prot_stop, safety_ok, stop_done};

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sy1_q <= '0;
            sy2_q <= '0;
        end
        else
        begin
            sy1_q <= raw;
            sy2_q <= sy1_q;
        end
    end

    logic [N_STN-1:0] start_s;
    logic [N_STN-1:0] stop_s;
    logic [N_STN-1:0] estop_s;
    logic [N_STN-1:0] esw_s;
    logic [N_STN-1:0] rst_s;
    logic             ha_s;
    logic             hb_s;
    logic             enable_s;
    logic             hold_s;
    logic             prot_s;
    logic             safe_s;
    logic             done_s;

    assign {start_s, stop_s, estop_s, esw_s, rst_s, ha_s, hb_s,
            enable_s, hold_s, prot_s, safe_s, done_s} = sy2_q;

    // ************************************************************
    // emergency latches
    // ************************************************************
    // latch sets win over a same-station reset
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            estop_lat_q <= '0;
            esw_lat_q   <= '0;
        end
        else
        begin
            estop_lat_q <= estop_s | (estop_lat_q & ~rst_s);
            esw_lat_q   <= esw_s | (esw_lat_q & ~rst_s);
        end
    end

    logic estop_any;
    logic esw_any;

    assign estop_any = |(estop_lat_q | estop_s);
    assign esw_any   = |(esw_lat_q | esw_s);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            supply_on_q <= 1'b0;
        else
            supply_on_q <= !esw_any;
    end

    // ************************************************************
    // mode tracking and permits
    // ************************************************************
    msc_pkg::msc_mode_e  mode_q;
    msc_pkg::msc_state_e st_q;
    msc_pkg::msc_state_e st_d;
    logic                keep_q;
    logic                keep_d;
    logic                mode_chg;
    logic                stop_any_s;
    logic                permit;
    logic                go_run;

    assign mode_chg   = cfg.mode != mode_q;
    assign stop_any_s = |(stop_s & stop_en) || prot_s;
    assign go_run     = st_q != msc_pkg::MSC_ST_RUN && st_d == msc_pkg::MSC_ST_RUN;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            mode_q <= msc_pkg::MSC_MODE_NORMAL;
        else
            mode_q <= cfg.mode;
    end

    // ************************************************************
    // initiation arms
    // ************************************************************
    logic st_arm_q;
    logic hold_arm_q;
    logic th_arm_q;
    logic en_arm_q;
    logic start_rel;
    logic start_all;
    logic both;
    logic none;
    logic one_hand;
    logic stop_rq;

    assign start_rel = ~|(start_s & start_req);
    assign start_all = &(start_s | ~start_req) && |start_req;
    assign both      = ha_s && hb_s;
    assign none      = !ha_s && !hb_s;
    assign one_hand  = ha_s ^ hb_s;

    // clearing on any stop forces a release after protective stops
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            st_arm_q <= 1'b0;
        else if (go_run || mode_chg || stop_rq)
            st_arm_q <= 1'b0;
        else if (start_rel)
            st_arm_q <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            hold_arm_q <= 1'b0;
        else if (go_run || mode_chg || !permit)
            hold_arm_q <= 1'b0;
        else if (!hold_s)
            hold_arm_q <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            th_arm_q <= 1'b0;
        else if (go_run || mode_chg || !permit)
            th_arm_q <= 1'b0;
        else if (none)
            th_arm_q <= 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            en_arm_q <= 1'b0;
        else if (go_run)
            en_arm_q <= 1'b0;
        else if (!enable_s)
            en_arm_q <= 1'b1;
    end

    // ************************************************************
    // two-hand window
    // ************************************************************
    logic [TW-1:0] th_cnt_q;
    logic          th_late_q;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            th_cnt_q <= '0;
        else if (none)
            th_cnt_q <= '0;
        else if (one_hand && th_cnt_q != TW'(TH_WIN_CYC))
            th_cnt_q <= th_cnt_q + TW'(1);
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            th_late_q <= 1'b0;
        else if (one_hand && th_cnt_q == TW'(TH_WIN_CYC))
            th_late_q <= 1'b1;
        else if (none)
            th_late_q <= 1'b0;
    end

    // ************************************************************
    // initiation and continuation per mode
    // ************************************************************
    logic init;
    logic cont;
    logic en_init;
    logic en_cont;

    assign en_init = !cfg.en_use || (enable_s && en_arm_q);
    assign en_cont = !cfg.en_use || enable_s;

    always_comb
    begin
        init = 1'b0;
        cont = 1'b0;
        case (mode_q)
            msc_pkg::MSC_MODE_NORMAL:
            begin
                init = start_all && st_arm_q;
                cont = 1'b1;
            end
            msc_pkg::MSC_MODE_HOLD:
            begin
                init = hold_s && hold_arm_q;
                cont = hold_s;
            end
            msc_pkg::MSC_MODE_TH1:
            begin
                init = both;
                cont = both;
            end
            msc_pkg::MSC_MODE_TH2:
            begin
                init = both && th_arm_q;
                cont = both;
            end
            msc_pkg::MSC_MODE_TH3:
            begin
                init = both && th_arm_q && !th_late_q;
                cont = both;
            end
            default:
            begin
                init = 1'b0;
                cont = 1'b0;
            end
        endcase
    end

    // safety feedback and enabling gate every start
    assign permit  = safe_s && !estop_any && !esw_any && !stop_any_s && en_cont;
    assign stop_rq = !permit || !cont || mode_chg;

    // ************************************************************
    // run and stop sequencing
    // ************************************************************
    logic [1:0] cat_eff;

    // an unusable category falls back to the safest stop
    assign cat_eff = (cfg.stop_cat == `MSC_CAT_BAD) ? `MSC_CAT0 : cfg.stop_cat;

    always_comb
    begin
        st_d   = st_q;
        keep_d = keep_q;
        case (st_q)
            msc_pkg::MSC_ST_IDLE, msc_pkg::MSC_ST_HELD:
            begin
                if (esw_any || estop_any)
                    st_d = msc_pkg::MSC_ST_IDLE;
                else if (permit && init && en_init && !mode_chg)
                    st_d = msc_pkg::MSC_ST_RUN;
            end
            msc_pkg::MSC_ST_RUN:
            begin
                if (esw_any || (estop_any && !cfg.estop_cat1))
                    st_d = msc_pkg::MSC_ST_IDLE;
                else if (estop_any)
                begin
                    st_d   = msc_pkg::MSC_ST_CSTOP;
                    keep_d = 1'b0;
                end
                else if (stop_rq)
                begin
                    if (cat_eff == `MSC_CAT0)
                        st_d = msc_pkg::MSC_ST_IDLE;
                    else
                    begin
                        st_d   = msc_pkg::MSC_ST_CSTOP;
                        keep_d = cat_eff == `MSC_CAT2;
                    end
                end
            end
            msc_pkg::MSC_ST_CSTOP:
            begin
                if (esw_any || (estop_any && !cfg.estop_cat1))
                    st_d = msc_pkg::MSC_ST_IDLE;
                else
                begin
                    if (estop_any)
                        keep_d = 1'b0;
                    if (done_s)
                        st_d = keep_d ? msc_pkg::MSC_ST_HELD : msc_pkg::MSC_ST_IDLE;
                end
            end
            default:
                st_d = msc_pkg::MSC_ST_IDLE;
        endcase
    end

    function automatic msc_pkg::msc_act_s act_of(input msc_pkg::msc_state_e s);
        msc_pkg::msc_act_s a;
        a.power     = s != msc_pkg::MSC_ST_IDLE;
        a.motion    = s == msc_pkg::MSC_ST_RUN;
        a.ctrl_stop = s == msc_pkg::MSC_ST_CSTOP;
        return a;
    endfunction : act_of

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q   <= msc_pkg::MSC_ST_IDLE;
            keep_q <= 1'b0;
            act_q  <= '0;
        end
        else
        begin
            st_q   <= st_d;
            keep_q <= keep_d;
            act_q  <= act_of(st_d);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cfg_err_q <= 1'b0;
        else
            cfg_err_q <= cfg.stop_cat == `MSC_CAT_BAD;
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_START_SAFE: assert property (go_run |-> safe_s && !stop_any_s)
        else $error("run entered without safety or with stop");
    AST_STOP_WINS: assert property (st_q == msc_pkg::MSC_ST_RUN && stop_any_s
        |=> !act_q.motion)
        else $error("motion kept under stop");
    AST_LATCH_HOLD: assert property (estop_lat_q[0] && !rst_s[0] |=> estop_lat_q[0])
        else $error("emergency latch lost without reset");
    AST_LOCAL_RESET: assert property ($fell(estop_lat_q[0]) |-> $past(rst_s[0]))
        else $error("latch cleared by a foreign reset");
    AST_NO_AUTO_RUN: assert property (st_q == msc_pkg::MSC_ST_IDLE && estop_any
        |=> st_q == msc_pkg::MSC_ST_IDLE ##1 !act_q.motion)
        else $error("run right after emergency reset");
    AST_ESW_OFF: assert property (esw_any |=> !supply_on_q && !act_q.power)
        else $error("power kept under switching off");
    AST_ESTOP_CAT0: assert property (estop_any && !cfg.estop_cat1
        |=> !act_q.power)
        else $error("category 0 emergency stop kept power");
    AST_HOLD_DROP: assert property (st_q == msc_pkg::MSC_ST_RUN
        && mode_q == msc_pkg::MSC_MODE_HOLD && !hold_s |=> !act_q.motion)
        else $error("hold-to-run kept motion");
    AST_TH_LATE: assert property (th_late_q && mode_q == msc_pkg::MSC_MODE_TH3
        |-> !go_run)
        else $error("late two-hand start accepted");
    AST_ENABLE_OFF: assert property (cfg.en_use && !enable_s
        |-> !go_run ##1 !act_q.motion)
        else $error("run without enabling");
    AST_MODE_NO_RUN: assert property (mode_chg |-> !go_run)
        else $error("mode change started operation");

    COV_RUN: cover property (go_run ##1 act_q.motion);
    COV_HELD: cover property (st_q == msc_pkg::MSC_ST_CSTOP ##1 st_q == msc_pkg::MSC_ST_HELD);
    COV_ESTOP: cover property ($rose(estop_lat_q[0]) ##[1:50] $fell(estop_lat_q[0]));

endmodule : msc_top
